// ==== flash_cmd.sv ====
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "flash_consts.svh"
module flash_cmd
   import flash_pkg::*;
#(
   parameter int ADDR_W = 19
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic select_n_in,
   input wire logic serial_clock_in,
   input wire logic host_to_device_line_in,
   output logic host_to_device_line_out,
   output logic host_to_device_line_oe_out,
   output logic device_to_host_out,
   output logic device_to_host_oe_out,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_awaddr_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   output logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   input wire logic [31:0] s_axi_araddr_in,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out
);
   if (ADDR_W < 16 || ADDR_W > 24) begin : g_bad_width
      $error("flash_cmd: ADDR_W out of range");
   end

   flash_mem_if #(.AW(ADDR_W)) mp ();
   flash_array #(.AW(ADDR_W)) u_array (.clock_in(clock_in), .m(mp.store));

   // ---------------------------------------------
   // pin synchronisers and edge detection
   // ---------------------------------------------
   logic [2:0] cs_q;
   logic [2:0] sck_q;
   logic [1:0] di_q;
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cs_q <= 3'h7;
         sck_q <= 3'h0;
         di_q <= 2'h0;
      end else if (ce_in) begin
         cs_q <= {cs_q[1:0], select_n_in};
         sck_q <= {sck_q[1:0], serial_clock_in};
         di_q <= {di_q[0], host_to_device_line_in};
      end
   end
   wire di = di_q[1];
   wire frame_start = cs_q[2] & ~cs_q[1];
   wire frame_end = ~cs_q[2] & cs_q[1];
   wire sck_rise = ~sck_q[2] & sck_q[1] & ~cs_q[1];
   wire sck_fall = sck_q[2] & ~sck_q[1] & ~cs_q[1];

   // ---------------------------------------------
   // command decode
   // ---------------------------------------------
   phase_t phase;
   pwr_t pwr;
   logic [5:0] bits;
   logic [7:0] op;
   logic [23:0] in_sr;
   logic [ADDR_W-1:0] rd_addr;
   logic [ADDR_W-1:0] walk;
   logic [ADDR_W-1:0] mask;
   logic [7:0] shreg;
   logic [2:0] out_cnt;
   logic is_status;
   logic wiping;
   logic wlatch;
   logic [2:0] protect;
   logic [11:0] pwr_cnt;
   logic do_q;
   logic io0_q;
   logic do_oe;
   logic io0_oe;

   wire [7:0] op_now = {in_sr[6:0], di};
   wire [23:0] sr_now = {in_sr[22:0], di};
   wire busy = wiping;
   wire [7:0] status_byte = {3'h0, protect, wlatch, busy};
   wire op_whole = op == `OP_WHOLE_WIPE_A || op == `OP_WHOLE_WIPE_B;
   wire op_region = op == `OP_SECTOR_WIPE || op == `OP_HALF_WIPE || op == `OP_BLOCK_WIPE;
   wire op_fast = op == `OP_FAST_READ || op == `OP_DUAL_READ;
   wire dual = op == `OP_DUAL_READ;
   wire known = op_now == `OP_WRITE_EN || op_now == `OP_WRITE_DIS ||
      op_now == `OP_STATUS || op_now == `OP_SECTOR_WIPE || op_now == `OP_HALF_WIPE ||
      op_now == `OP_BLOCK_WIPE || op_now == `OP_WHOLE_WIPE_A ||
      op_now == `OP_WHOLE_WIPE_B || op_now == `OP_READ || op_now == `OP_FAST_READ ||
      op_now == `OP_DUAL_READ || op_now == `OP_SLEEP_ENTRY;
   // asleep: release only; busy: status only
   wire allowed = (pwr == PW_ON) ? (busy ? op_now == `OP_STATUS : known) :
      (op_now == `OP_RELEASE && pwr != PW_WAKE);
   wire cmd_end = frame_end && phase == PH_IN;
   wire len8 = bits == `OPCODE_BITS;
   wire len32 = bits == `ADDR_CMD_BITS;
   wire wipe_req = cmd_end && wlatch && ((op_whole && len8) || (op_region && len32));
   wire [ADDR_W-1:0] inv_addr = ~rd_addr;
   // guard level n covers the top 2^(n-1) blocks, level 7 everything only when ADDR_W is 22 or less
   wire guarded = protect != 3'h0 &&
      (op_whole || (inv_addr >> (`BLOCK_AW - 5'd1 + 5'(protect))) == '0);
   wire wipe_go = wipe_req && !guarded;
   wire [4:0] region_aw = op == `OP_SECTOR_WIPE ? `SECTOR_AW :
      op == `OP_HALF_WIPE ? `HALF_AW : op == `OP_BLOCK_WIPE ? `BLOCK_AW : 5'(ADDR_W);
   wire [ADDR_W-1:0] region_mask = ~({ADDR_W{1'b1}} << region_aw);
   wire walk_last = (walk & mask) == mask;
   wire do_we = cmd_end && len8 && op == `OP_WRITE_EN;
   wire do_wd = cmd_end && len8 && op == `OP_WRITE_DIS;
   wire do_sleep = cmd_end && len8 && op == `OP_SLEEP_ENTRY;
   wire do_release = cmd_end && len8 && op == `OP_RELEASE;
   wire [7:0] out_src = is_status ? status_byte : mp.rdata;
   wire [7:0] cur = (out_cnt == 3'h0) ? out_src : shreg;
   wire [2:0] last_cnt = dual ? 3'h3 : 3'h7;

   // ---------------------------------------------
   // serial frame handling
   // ---------------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         phase <= PH_IN;
         bits <= 6'h0;
         op <= 8'h0;
         in_sr <= 24'h0;
         rd_addr <= '0;
         shreg <= 8'h0;
         out_cnt <= 3'h0;
         is_status <= 1'b0;
         do_q <= 1'b0;
         io0_q <= 1'b0;
         do_oe <= 1'b0;
         io0_oe <= 1'b0;
      end else if (ce_in) begin
         if (frame_start || frame_end) begin
            phase <= PH_IN;
            bits <= 6'h0;
            out_cnt <= 3'h0;
            is_status <= 1'b0;
            do_oe <= 1'b0;
            io0_oe <= 1'b0;
         end else if (sck_rise && phase == PH_IN) begin
            in_sr <= sr_now;
            if (bits != `BITS_MAX) begin
               bits <= bits + 6'h1;
            end
            if (bits == `OPCODE_BITS - 6'h1) begin
               op <= op_now;
               if (!allowed) begin
                  phase <= PH_SKIP;
               end else if (op_now == `OP_STATUS) begin
                  phase <= PH_OUT;
                  is_status <= 1'b1;
               end
            end
            if (bits == `ADDR_CMD_BITS - 6'h1) begin
               rd_addr <= sr_now[ADDR_W-1:0];
               if (op == `OP_READ) begin
                  phase <= PH_OUT;
               end
            end
            if (bits == `FAST_CMD_BITS - 6'h1 && op_fast) begin
               phase <= PH_OUT;
            end
         end else if (sck_fall && phase == PH_OUT) begin
            do_oe <= 1'b1;
            io0_oe <= dual;
            do_q <= cur[7];
            io0_q <= cur[6];
            shreg <= dual ? {cur[5:0], 2'h0} : {cur[6:0], 1'b0};
            out_cnt <= (out_cnt == last_cnt) ? 3'h0 : out_cnt + 3'h1;
            if (out_cnt == 3'h0 && !is_status) begin
               rd_addr <= rd_addr + ADDR_W'(1);
            end
         end
      end
   end

   // ---------------------------------------------
   // self-timed wipe engine
   // ---------------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         wiping <= 1'b0;
         wlatch <= 1'b0;
         walk <= '0;
         mask <= '0;
      end else if (ce_in) begin
         if (wiping) begin
            walk <= walk + ADDR_W'(1);
            if (walk_last) begin
               wiping <= 1'b0;
               wlatch <= 1'b0;
            end
         end else if (wipe_go) begin
            wiping <= 1'b1;
            walk <= rd_addr & ~region_mask;
            mask <= region_mask;
         end
         if (do_we) begin
            wlatch <= 1'b1;
         end else if (do_wd) begin
            wlatch <= 1'b0;
         end
      end
   end

   assign mp.en = ce_in;
   assign mp.we = wiping;
   assign mp.addr = wiping ? walk : rd_addr;
   assign mp.wdata = `ERASED_BYTE;

   // ---------------------------------------------
   // deep power-down
   // ---------------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pwr <= PW_ON;
         pwr_cnt <= 12'h0;
      end else if (ce_in) begin
         case (pwr)
            PW_ON: begin
               if (do_sleep) begin
                  pwr <= PW_ENTER;
                  pwr_cnt <= 12'(`SLEEP_ENTRY_CYCLES);
               end
            end
            PW_ENTER, PW_SLEEP: begin
               if (do_release) begin
                  pwr <= PW_WAKE;
                  pwr_cnt <= 12'(`RELEASE_DELAY_CYCLES);
               end else if (pwr == PW_ENTER) begin
                  if (pwr_cnt <= 12'h1) begin
                     pwr <= PW_SLEEP;
                  end else begin
                     pwr_cnt <= pwr_cnt - 12'h1;
                  end
               end
            end
            PW_WAKE: begin
               if (pwr_cnt <= 12'h1) begin
                  pwr <= PW_ON;
               end else begin
                  pwr_cnt <= pwr_cnt - 12'h1;
               end
            end
            default: pwr <= PW_ON;
         endcase
      end
   end

   // ---------------------------------------------
   // axi4-lite register slave
   // ---------------------------------------------
   logic aw_full;
   logic w_full;
   logic aw_hit;
   logic [2:0] w_data;
   logic w_lane0;
   logic bvalid;
   logic [1:0] bresp;
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;
   wire aw_take = s_axi_awvalid_in && !aw_full;
   wire w_take = s_axi_wvalid_in && !w_full;
   wire ar_take = s_axi_arvalid_in && !rvalid;
   wire [31:0] status_word = {23'h0, pwr != PW_ON, status_byte};
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_hit <= 1'b0;
         w_data <= 3'h0;
         w_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `RESP_OKAY;
         protect <= `PROTECT_RESET;
      end else if (ce_in) begin
         if (aw_take) begin
            aw_full <= 1'b1;
            aw_hit <= s_axi_awaddr_in == `REG_PROTECT;
         end
         if (w_take) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata_in[2:0];
            w_lane0 <= s_axi_wstrb_in[0];
         end
         if (bvalid && s_axi_bready_in) begin
            bvalid <= 1'b0;
         end else if (aw_full && w_full && !bvalid) begin
            bvalid <= 1'b1;
            bresp <= aw_hit ? `RESP_OKAY : `RESP_SLVERR;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            if (aw_hit && w_lane0) begin
               protect <= w_data;
            end
         end
         if (rvalid && s_axi_rready_in) begin
            rvalid <= 1'b0;
         end else if (ar_take) begin
            rvalid <= 1'b1;
            rresp <= (s_axi_araddr_in == `REG_STATUS || s_axi_araddr_in == `REG_PROTECT) ?
               `RESP_OKAY : `RESP_SLVERR;
            rdata <= s_axi_araddr_in == `REG_STATUS ? status_word :
               s_axi_araddr_in == `REG_PROTECT ? {29'h0, protect} : 32'h0;
         end
      end
   end

   assign s_axi_awready_out = !aw_full;
   assign s_axi_wready_out = !w_full;
   assign s_axi_bvalid_out = bvalid;
   assign s_axi_bresp_out = bresp;
   assign s_axi_arready_out = !rvalid;
   assign s_axi_rvalid_out = rvalid;
   assign s_axi_rdata_out = rdata;
   assign s_axi_rresp_out = rresp;
   assign device_to_host_out = do_q;
   assign device_to_host_oe_out = do_oe;
   assign host_to_device_line_out = io0_q;
   assign host_to_device_line_oe_out = io0_oe;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   localparam int SLP_MAX = `SLEEP_ENTRY_CYCLES + 1;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in || !ce_in);

   property p_wipe_latch; $rose(wiping) |-> $past(wlatch); endproperty
   a_wipe_latch: assert property (p_wipe_latch) else $error("wipe without latch");
   property p_busy_hold; wipe_go |=> busy [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
   property p_latch_clear; $fell(wiping) |-> !wlatch && !status_byte[`SR_BUSY]; endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch kept after wipe");
   property p_busy_read; busy && phase == PH_OUT |-> is_status; endproperty
   a_busy_read: assert property (p_busy_read) else $error("read served while busy");
   property p_sleep; do_sleep && pwr == PW_ON |-> ##[1:SLP_MAX] pwr == PW_SLEEP; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry late");
   property p_asleep_mute; pwr != PW_ON |-> !do_oe; endproperty
   a_asleep_mute: assert property (p_asleep_mute) else $error("output while asleep");
   property p_guard; wipe_req && guarded |=> !wiping; endproperty
   a_guard: assert property (p_guard) else $error("guarded wipe ran");
   property p_align; $rose(wiping) |-> (walk & mask) == '0 && mp.we; endproperty
   a_align: assert property (p_align) else $error("wipe not region aligned");
   property p_step;
      sck_fall && phase == PH_OUT && out_cnt == 3'h0 && !is_status && !frame_end
         |=> rd_addr == $past(rd_addr) + ADDR_W'(1);
   endproperty
   a_step: assert property (p_step) else $error("read address did not step");
   property p_exact; cmd_end && !len8 && !len32 |=> !$rose(wiping) && pwr != PW_ENTER; endproperty
   a_exact: assert property (p_exact) else $error("misframed command acted");

   c_wipe_done: cover property ($fell(wiping));
   c_read: cover property (sck_fall && phase == PH_OUT && !is_status && !dual);
   c_dual: cover property (io0_oe && do_oe);
   c_sleep: cover property (pwr == PW_SLEEP ##1 pwr == PW_WAKE);
endmodule // flash_cmd
`default_nettype wire

// ==== flash_consts.svh ====
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH
// opcodes
`define OP_WRITE_EN 8'h06
`define OP_WRITE_DIS 8'h04
`define OP_STATUS 8'h05
`define OP_SECTOR_WIPE 8'h20
`define OP_HALF_WIPE 8'h52
`define OP_BLOCK_WIPE 8'hd8
`define OP_WHOLE_WIPE_A 8'hc7
`define OP_WHOLE_WIPE_B 8'h60
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_DUAL_READ 8'h3b
`define OP_SLEEP_ENTRY 8'hb9
`define OP_RELEASE 8'hab
// region sizes as address widths
`define SECTOR_AW 5'd12
`define HALF_AW 5'd15
`define BLOCK_AW 5'd16
// frame lengths in serial clocks
`define OPCODE_BITS 6'd8
`define ADDR_CMD_BITS 6'd32
`define FAST_CMD_BITS 6'd40
`define BITS_MAX 6'h3f
`define ERASED_BYTE 8'hff
// status word layout
`define SR_BUSY 0
`define SR_WLATCH 1
`define SR_PROT_LSB 2
`define SR_SLEEP 8
// register map
`define REG_STATUS 32'h0000_0000
`define REG_PROTECT 32'h0000_0004
`define PROTECT_RESET 3'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// timing
`define CLK_PERIOD_NS 40
`define SLEEP_ENTRY_TIME_NS 3000
`define SLEEP_ENTRY_CYCLES (`SLEEP_ENTRY_TIME_NS / `CLK_PERIOD_NS)
`define RELEASE_DELAY_NS 3000
`define RELEASE_DELAY_CYCLES ((`RELEASE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== flash_pkg.sv ====
package flash_pkg;
   typedef enum logic [2:0] {
      PH_IN = 3'b001,
      PH_OUT = 3'b010,
      PH_SKIP = 3'b100
   } phase_t;
   typedef enum logic [3:0] {
      PW_ON = 4'b0001,
      PW_ENTER = 4'b0010,
      PW_SLEEP = 4'b0100,
      PW_WAKE = 4'b1000
   } pwr_t;
endpackage

// ==== flash_mem_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface flash_mem_if #(parameter int AW = 19);
   logic en;
   logic we;
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl(output en, we, addr, wdata, input rdata);
   modport store(input en, we, addr, wdata, output rdata);
endinterface // flash_mem_if
`default_nettype wire

// ==== flash_array.sv ====
`timescale 1ns/100ps
`default_nettype none
module flash_array #(
   parameter int AW = 19
) (
   input wire logic clock_in,
   flash_mem_if.store m
);
   logic [7:0] mem [0:(1<<AW)-1];

   if (AW < 1 || AW > 24) begin : g_bad_aw
      $error("flash_array: AW out of range");
   end

   // read data always registered
   always_ff @(posedge clock_in) begin
      if (m.en) begin
         if (m.we) begin
            mem[m.addr] <= m.wdata;
         end
         m.rdata <= mem[m.addr];
      end
   end
endmodule // flash_array
`default_nettype wire

// ==== spi_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
   output logic sel_n_out,
   output logic sclk_out,
   output logic mosi_out,
   output logic mosi_oe_out,
   input wire logic io0_in,
   input wire logic io1_in
);
   logic [7:0] rd[$];
   initial begin
      sel_n_out = 1'b1;
      sclk_out = 1'b0;
      mosi_out = 1'b0;
      mosi_oe_out = 1'b1;
   end
   // -----------------------------
   // one framed transfer, mode 0
   // -----------------------------
   task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int abits,
                        input int dummy, input int nrd, input bit dual);
      logic [31:0] sh;
      logic [7:0] b;
      int i;
      int j;
      int k;
      rd.delete();
      sh = {op, adr};
      b = 8'h00;
      #213 sel_n_out <= 1'b0;
      for (i = 0; i < 8 + abits + dummy; i++) begin
         mosi_oe_out <= (i < 8 + abits);
         mosi_out <= (i < 32) ? sh[31 - i] : 1'b0;
         #160 sclk_out <= 1'b1;
         #160 sclk_out <= 1'b0;
      end
      for (k = 0; k < nrd; k++) begin
         for (j = 0; j < (dual ? 4 : 8); j++) begin
            #160 sclk_out <= 1'b1;
            #159;
            b = dual ? {b[5:0], io1_in, io0_in} : {b[6:0], io1_in};
            #1 sclk_out <= 1'b0;
         end
         rd.push_back(b);
      end
      // select rises right after the last whole byte
      #200 sel_n_out <= 1'b1;
      // take the data line back only once the device has let go of it
      #400 mosi_oe_out <= 1'b1;
   endtask
endmodule // spi_host_model
`default_nettype wire

// ==== serial_flash_erase_read_sleep_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "flash_consts.svh"
module serial_flash_erase_read_sleep_tb
   import flash_pkg::*;
;
   // -----------------------------
   // signals and instances
   // -----------------------------
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
   wire awready, wready, bvalid, arready, rvalid, sel_n, sclk, h_mosi, h_oe;
   wire d_io0, d_io0_oe, d_out, d_oe;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   logic pat = 1'b0;
   int oe_cnt = 0;
   int fails = 0, tests_run = 0, cyc = 0, m_latch = 0, m_prot = 0, m_sleep = 0;
   // released lines never hold their last value
   wire io0 = d_io0_oe ? d_io0 : (h_oe ? h_mosi : pat);
   wire io1 = d_oe ? d_out : ~pat;
   always #20 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      pat <= ~pat;
      cyc <= cyc + 1;
      if (d_oe === 1'b1) oe_cnt <= oe_cnt + 1;
   end
   flash_cmd #(.ADDR_W(16)) flash_cmd_i (.clock_in(clock_in), .rst_in(rst_in), .ce_in(1'b1),
      .select_n_in(sel_n), .serial_clock_in(sclk), .host_to_device_line_in(io0),
      .host_to_device_line_out(d_io0), .host_to_device_line_oe_out(d_io0_oe),
      .device_to_host_out(d_out), .device_to_host_oe_out(d_oe),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
      .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));
   spi_host_model spi_host_model_i (.sel_n_out(sel_n), .sclk_out(sclk), .mosi_out(h_mosi),
      .mosi_oe_out(h_oe), .io0_in(io0), .io1_in(io1));
   // -----------------------------
   // tasks
   // -----------------------------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic logic [31:0] exp_stat(input int busy);
      return (m_sleep << 8) | (m_prot << 2) | (m_latch << 1) | busy;
   endfunction
   task axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clock_in);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clock_in);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (n == 50) begin
         check("write answer", 0, 1);
         final_report();
      end
      r = bresp;
      bready <= 1'b0;
   endtask
   task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clock_in);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clock_in);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (n == 50) begin
         check("read answer", 0, 1);
         final_report();
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task stat(input string what);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(`REG_STATUS, d, r);
      check(what, d, exp_stat(0));
   endtask
   task cmd(input logic [7:0] op);
      spi_host_model_i.frame(op, 24'h0, 0, 0, 0, 0);
   endtask
   // -----------------------------
   // sequence
   // -----------------------------
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] refused[3];
      logic [7:0] rops[3];
      int i, j, k, a, b, t0, aw, oe0;
      refused = '{`OP_SECTOR_WIPE, `OP_WHOLE_WIPE_A, `OP_BLOCK_WIPE};
      rops = '{`OP_READ, `OP_FAST_READ, `OP_DUAL_READ};
      d = $urandom(47);
      repeat (6) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      stat("reset status");
      axi_rd(32'h8, d, r);
      check("unmapped resp", r, `RESP_SLVERR);
      check("unmapped data", d, 0);
      axi_wr(`REG_STATUS, 32'h1, r);
      check("status write resp", r, `RESP_SLVERR);
      axi_wr(`REG_PROTECT, 32'h1, r);
      m_prot = 1;
      check("protect write resp", r, `RESP_OKAY);
      cmd(`OP_WRITE_EN);
      m_latch = 1;
      stat("latch set");
      for (i = 0; i < 3; i++) begin
         spi_host_model_i.frame(refused[i], 24'h0, (i == 1) ? 0 : 24, 0, 0, 0);
         stat("guarded wipe");
      end
      axi_wr(`REG_PROTECT, 32'h0, r);
      m_prot = 0;
      cmd(`OP_WRITE_DIS);
      m_latch = 0;
      cmd(`OP_WHOLE_WIPE_B);
      stat("wipe without latch");
      cmd(`OP_WRITE_EN);
      m_latch = 1;
      spi_host_model_i.frame(`OP_SECTOR_WIPE, 24'h0, 23, 0, 0, 0);
      stat("short wipe frame");
      for (j = 0; j < 2; j++) begin
         aw = j ? 15 : 12;
         a = $urandom % 65536;
         cmd(`OP_WRITE_EN);
         spi_host_model_i.frame(j ? `OP_HALF_WIPE : `OP_SECTOR_WIPE, 24'(a), 24, 0, 0, 0);
         t0 = cyc;
         spi_host_model_i.frame(`OP_STATUS, 24'h0, 0, 0, 1, 0);
         check("busy status", spi_host_model_i.rd[0], 8'h03);
         oe0 = oe_cnt;
         spi_host_model_i.frame(`OP_READ, 24'(a), 24, 0, 2, 0);
         check("read while busy", oe_cnt - oe0, 0);
         for (i = 0; i < 15000; i++) begin
            axi_rd(`REG_STATUS, d, r);
            if (d[0] === 1'b0) break;
         end
         if (i == 15000) begin
            check("wipe end", 0, 1);
            final_report();
         end
         m_latch = 0;
         check("latch after wipe", d, exp_stat(0));
         check("wipe time", (cyc - t0 > (1 << aw) - 20) && (cyc - t0 < (1 << aw) + 10), 1);
         for (k = 0; k < 3; k++) begin
            b = (a & ~((1 << aw) - 1)) + $urandom % ((1 << aw) - 4);
            spi_host_model_i.frame(rops[k], 24'(b), 24, (k == 0) ? 0 : 8, 4, k == 2);
            for (i = 0; i < 4; i++) begin
               check("erased byte", spi_host_model_i.rd[i], `ERASED_BYTE);
            end
         end
      end
      cmd(`OP_SLEEP_ENTRY);
      repeat (80) @(posedge clock_in);
      m_sleep = 1;
      stat("asleep");
      oe0 = oe_cnt;
      spi_host_model_i.frame(`OP_STATUS, 24'h0, 0, 0, 1, 0);
      check("status while asleep", oe_cnt - oe0, 0);
      cmd(`OP_WRITE_EN);
      stat("enable while asleep");
      cmd(`OP_RELEASE);
      repeat (80) @(posedge clock_in);
      m_sleep = 0;
      stat("awake");
      oe0 = oe_cnt;
      spi_host_model_i.frame(`OP_STATUS, 24'h0, 0, 0, 1, 0);
      check("status after wake", spi_host_model_i.rd[0], 8'h00);
      check("status drive after wake", oe_cnt > oe0, 1);
      final_report();
   end
endmodule // serial_flash_erase_read_sleep_tb
`default_nettype wire
